// ### hdl/npr_host.sv
// host controller driving an asynchronous 8-bit page flash over its pins
// assumes a 50 MHz clock, ready_busy_n pulled up outside, io wire resolved outside
`include "npr_params.svh"
module npr_host #(
  parameter int P_LOAD_WAIT = `NPR_LOAD_CYC,
  parameter int P_BUSY_WAIT = `NPR_BUSY_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // operation request
  input wire logic i_op_valid,
  input wire npr_pkg::npr_op_t i_op,
  input wire npr_pkg::npr_area_t i_area,
  input wire logic [23:0] i_addr,
  input wire logic [9:0] i_len,
  output logic o_idle,
  output logic o_done,
  output logic o_timeout,
  output npr_pkg::npr_area_t o_area,
  // write data stream
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_data,
  output logic o_wr_ready,
  // read data stream and status
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic [7:0] o_status,
  output logic o_fail,
  // flash pins
  output logic o_cle,
  output logic o_ale,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_output_strobe_n,
  output logic o_wp_n,
  input wire logic [7:0] i_io,
  output logic [7:0] o_io,
  output logic o_io_oe,
  input wire logic i_ready_busy_n
);

  typedef logic [17:0] tmr_t;

  npr_pkg::npr_state_t state_r, state_nxt;
  npr_pkg::npr_op_t op_r, op_nxt;
  npr_pkg::npr_area_t area_r, area_nxt;
  logic [1:0] phase_r, phase_nxt;
  tmr_t tmr_r, tmr_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [1:0] acnt_r, acnt_nxt;
  logic [1:0] aidx_r, aidx_nxt;
  logic [9:0] cnt_r, cnt_nxt;
  logic stat_r, stat_nxt;
  logic cle_nxt, ale_nxt, ce_n_nxt, we_n_nxt, re_n_nxt, oe_nxt;
  logic [7:0] io_nxt, rd_data_nxt, status_nxt;
  logic rd_valid_nxt, done_nxt, timeout_nxt, wr_ready_nxt;

  // synchronised pins
  logic [8:0] pins_s;
  wire logic [7:0] io_s = pins_s[7:0];
  wire logic rdy_s = pins_s[8];

  npr_sync #(.W(9)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_ready_busy_n, i_io}),
    .o_q(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decodes and selections
  wire logic tick = (tmr_r == '0);
  wire logic wr_take = o_wr_ready & i_wr_valid;
  wire logic wc_done = (phase_r == 2'd2) & tick;
  wire logic [7:0] abyte = addr_r[aidx_r * `NPR_BYTE_W +: `NPR_BYTE_W];
  wire logic [7:0] wbyte = (state_r == npr_pkg::NPR_S_CMD) ? cmd_r :
                           (state_r == npr_pkg::NPR_S_ADDR) ? abyte : o_io;
  // status and reset may go to a busy device, all others wait for ready
  wire logic op_free = (i_op == npr_pkg::NPR_OP_STATUS) | (i_op == npr_pkg::NPR_OP_RESET);
  wire logic accept = o_idle & i_op_valid & (rdy_s | op_free);
  wire logic [7:0] area_cmd = (i_area == npr_pkg::NPR_AREA_SECOND) ? `NPR_CMD_AREA_B :
                              (i_area == npr_pkg::NPR_AREA_SPARE) ? `NPR_CMD_AREA_C :
                              `NPR_CMD_AREA_A;
  wire logic [7:0] first_cmd = (i_op == npr_pkg::NPR_OP_ERASE) ? `NPR_CMD_ERASE :
                               (i_op == npr_pkg::NPR_OP_STATUS) ? `NPR_CMD_STATUS :
                               (i_op == npr_pkg::NPR_OP_RESET) ? `NPR_CMD_RESET : area_cmd;
  wire logic rdy_go = rdy_s | tick;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    area_nxt = area_r;
    phase_nxt = phase_r;
    tmr_nxt = tick ? tmr_r : tmr_r - tmr_t'(1);
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    acnt_nxt = acnt_r;
    aidx_nxt = aidx_r;
    cnt_nxt = cnt_r;
    stat_nxt = stat_r;
    cle_nxt = o_cle;
    ale_nxt = o_ale;
    ce_n_nxt = o_ce_n;
    we_n_nxt = o_we_n;
    re_n_nxt = o_output_strobe_n;
    oe_nxt = o_io_oe;
    io_nxt = o_io;
    rd_data_nxt = o_rd_data;
    status_nxt = o_status;
    rd_valid_nxt = 1'b0;
    done_nxt = 1'b0;
    timeout_nxt = o_timeout;
    wr_ready_nxt = 1'b0;
    unique case (state_r)
      npr_pkg::NPR_S_IDLE: begin
        if (accept) begin
          op_nxt = i_op;
          addr_nxt = i_addr;
          cnt_nxt = i_len;
          cmd_nxt = first_cmd;
          timeout_nxt = 1'b0;
          stat_nxt = 1'b0;
          ce_n_nxt = 1'b0;
          phase_nxt = 2'd0;
          tmr_nxt = '0;
          state_nxt = npr_pkg::NPR_S_CMD;
          if (i_op == npr_pkg::NPR_OP_READ || i_op == npr_pkg::NPR_OP_PROG) begin
            area_nxt = i_area;
          end
        end
      end
      npr_pkg::NPR_S_CMD, npr_pkg::NPR_S_ADDR, npr_pkg::NPR_S_WDATA: begin
        // one write cycle: drive byte and strobe low together, strobe high, hold then release
        if (phase_r == 2'd0) begin
          if (state_r != npr_pkg::NPR_S_WDATA || wr_take) begin
            io_nxt = (state_r == npr_pkg::NPR_S_WDATA) ? i_wr_data : wbyte;
            oe_nxt = 1'b1;
            cle_nxt = (state_r == npr_pkg::NPR_S_CMD);
            ale_nxt = (state_r == npr_pkg::NPR_S_ADDR);
            we_n_nxt = 1'b0;
            tmr_nxt = tmr_t'(`NPR_WP_CYC - 1);
            phase_nxt = 2'd1;
          end else begin
            wr_ready_nxt = 1'b1;
          end
        end else if (phase_r == 2'd1 && tick) begin
          we_n_nxt = 1'b1;
          tmr_nxt = tmr_t'(`NPR_WH_CYC - 1);
          phase_nxt = 2'd2;
        end else if (wc_done) begin
          cle_nxt = 1'b0;
          ale_nxt = 1'b0;
          oe_nxt = 1'b0;
          phase_nxt = 2'd0;
          if (state_r == npr_pkg::NPR_S_CMD) begin
            unique case (cmd_r)
              `NPR_CMD_LOAD: begin
                acnt_nxt = `NPR_ADDR_CYC_PAGE;
                aidx_nxt = `NPR_ADDR_IDX_COL;
                state_nxt = npr_pkg::NPR_S_ADDR;
              end
              `NPR_CMD_ERASE: begin
                acnt_nxt = `NPR_ADDR_CYC_BLOCK;
                aidx_nxt = `NPR_ADDR_IDX_ROW;
                state_nxt = npr_pkg::NPR_S_ADDR;
              end
              `NPR_CMD_LOAD_GO, `NPR_CMD_ERASE_GO, `NPR_CMD_RESET: begin
                tmr_nxt = tmr_t'(`NPR_WB_CYC - 1);
                state_nxt = npr_pkg::NPR_S_WB;
              end
              `NPR_CMD_STATUS: begin
                tmr_nxt = tmr_t'(`NPR_WHR_CYC - 1);
                state_nxt = npr_pkg::NPR_S_WHR;
              end
              default: begin
                // pointer byte sent; program follows it with the load command
                if (op_r == npr_pkg::NPR_OP_PROG) begin
                  cmd_nxt = `NPR_CMD_LOAD;
                end else begin
                  acnt_nxt = `NPR_ADDR_CYC_PAGE;
                  aidx_nxt = `NPR_ADDR_IDX_COL;
                  state_nxt = npr_pkg::NPR_S_ADDR;
                end
              end
            endcase
          end else if (state_r == npr_pkg::NPR_S_ADDR) begin
            acnt_nxt = acnt_r - 2'd1;
            aidx_nxt = aidx_r + 2'd1;
            if (acnt_r == 2'd1) begin
              if (op_r == npr_pkg::NPR_OP_READ) begin
                tmr_nxt = tmr_t'(`NPR_WB_CYC - 1);
                state_nxt = npr_pkg::NPR_S_WB;
              end else if (op_r == npr_pkg::NPR_OP_ERASE) begin
                cmd_nxt = `NPR_CMD_ERASE_GO;
                state_nxt = npr_pkg::NPR_S_CMD;
              end else if (cnt_r == '0) begin
                ce_n_nxt = 1'b1;
                tmr_nxt = tmr_t'(`NPR_CEH_CYC - 1);
                state_nxt = npr_pkg::NPR_S_CEH;
              end else begin
                state_nxt = npr_pkg::NPR_S_WDATA;
              end
            end
          end else begin
            cnt_nxt = cnt_r - 10'd1;
            if (cnt_r == 10'd1) begin
              cmd_nxt = `NPR_CMD_LOAD_GO;
              state_nxt = npr_pkg::NPR_S_CMD;
            end
          end
        end
      end
      npr_pkg::NPR_S_WB: begin
        // busy may take up to this long to show
        if (tick) begin
          tmr_nxt = (op_r == npr_pkg::NPR_OP_READ) ? tmr_t'(P_LOAD_WAIT - 1) :
                    tmr_t'(P_BUSY_WAIT - 1);
          state_nxt = npr_pkg::NPR_S_WRDY;
        end
      end
      npr_pkg::NPR_S_WRDY: begin
        if (rdy_go) begin
          timeout_nxt = ~rdy_s;
          phase_nxt = 2'd0;
          tmr_nxt = '0;
          if (op_r == npr_pkg::NPR_OP_READ) begin
            state_nxt = (cnt_r == '0) ? npr_pkg::NPR_S_CEH : npr_pkg::NPR_S_RDATA;
            ce_n_nxt = (cnt_r == '0);
          end else if (op_r == npr_pkg::NPR_OP_RESET) begin
            // reset puts pointer in first half
            area_nxt = npr_pkg::NPR_AREA_FIRST;
            ce_n_nxt = 1'b1;
            tmr_nxt = tmr_t'(`NPR_CEH_CYC - 1);
            state_nxt = npr_pkg::NPR_S_CEH;
          end else begin
            if (area_r != npr_pkg::NPR_AREA_SPARE) begin
              area_nxt = npr_pkg::NPR_AREA_FIRST;
            end
            cmd_nxt = `NPR_CMD_STATUS;
            state_nxt = npr_pkg::NPR_S_CMD;
          end
        end
      end
      npr_pkg::NPR_S_WHR: begin
        if (tick) begin
          cnt_nxt = 10'd1;
          stat_nxt = 1'b1;
          phase_nxt = 2'd0;
          state_nxt = npr_pkg::NPR_S_RDATA;
        end
      end
      npr_pkg::NPR_S_RDATA: begin
        if (phase_r == 2'd0) begin
          re_n_nxt = 1'b0;
          // sample after access time plus sync delay
          tmr_nxt = tmr_t'(`NPR_REA_CYC - 1);
          phase_nxt = 2'd1;
        end else if (phase_r == 2'd1 && tick) begin
          re_n_nxt = 1'b1;
          tmr_nxt = tmr_t'(`NPR_REH_CYC - 1);
          phase_nxt = 2'd2;
          if (stat_r) begin
            status_nxt = io_s;
          end else begin
            // raw bytes for ecc and mark scan
            rd_data_nxt = io_s;
            rd_valid_nxt = 1'b1;
          end
        end else if (wc_done) begin
          cnt_nxt = cnt_r - 10'd1;
          phase_nxt = 2'd0;
          if (cnt_r == 10'd1) begin
            ce_n_nxt = 1'b1;
            tmr_nxt = tmr_t'(`NPR_CEH_CYC - 1);
            state_nxt = npr_pkg::NPR_S_CEH;
          end
        end
      end
      npr_pkg::NPR_S_CEH: begin
        if (tick) begin
          done_nxt = 1'b1;
          state_nxt = npr_pkg::NPR_S_IDLE;
          if (area_r == npr_pkg::NPR_AREA_SECOND) begin
            area_nxt = npr_pkg::NPR_AREA_FIRST;
          end
        end
      end
      default: begin
        state_nxt = npr_pkg::NPR_S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and bookkeeping registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= npr_pkg::NPR_S_IDLE;
      op_r <= npr_pkg::NPR_OP_READ;
      phase_r <= 2'd0;
      tmr_r <= '0;
      cmd_r <= `NPR_CMD_AREA_A;
      addr_r <= '0;
      acnt_r <= 2'd0;
      aidx_r <= 2'd0;
      cnt_r <= '0;
      stat_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      phase_r <= phase_nxt;
      tmr_r <= tmr_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      acnt_r <= acnt_nxt;
      aidx_r <= aidx_nxt;
      cnt_r <= cnt_nxt;
      stat_r <= stat_nxt;
    end
  end

  // pin registers, idle level after reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_ce_n <= 1'b1;
      o_we_n <= 1'b1;
      o_output_strobe_n <= 1'b1;
      o_wp_n <= 1'b0;
      o_io <= '0;
      o_io_oe <= 1'b0;
    end else begin
      o_cle <= cle_nxt;
      o_ale <= ale_nxt;
      o_ce_n <= ce_n_nxt;
      o_we_n <= we_n_nxt;
      o_output_strobe_n <= re_n_nxt;
      o_wp_n <= 1'b1;
      o_io <= io_nxt;
      o_io_oe <= oe_nxt;
    end
  end

  // user-side registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      area_r <= npr_pkg::NPR_AREA_FIRST;
      o_idle <= 1'b0;
      o_done <= 1'b0;
      o_timeout <= 1'b0;
      o_wr_ready <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
      o_status <= '0;
    end else begin
      area_r <= area_nxt;
      o_idle <= (state_nxt == npr_pkg::NPR_S_IDLE);
      o_done <= done_nxt;
      o_timeout <= timeout_nxt;
      o_wr_ready <= wr_ready_nxt;
      o_rd_valid <= rd_valid_nxt;
      o_rd_data <= rd_data_nxt;
      o_status <= status_nxt;
    end
  end

  assign o_fail = o_status[`NPR_ST_FAIL_BIT];
  assign o_area = area_r;

endmodule

// ### hdl/npr_sync.sv
// three-stage input synchroniser for pins from outside the clock domain
// assumes a single clock; a bit changes once the second and third stages agree
module npr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // asynchronous pins in, clean levels out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // shift chain; first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per bit: accept a change once stages two and three agree
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        o_q[g] <= 1'b0;
      end else if (s2_r[g] == s3_r[g]) begin
        o_q[g] <= s3_r[g];
      end
    end
  end

endmodule

// ### inc/npr_params.svh
// constants for the page-pointer host controller: command codes, timing, layout
// assumes a 50 MHz clock; every cycle count except NPR_SYNC_LAT is derived from a time at that rate
//
// Notes on behaviour
// - host holds select high longer than 100 ns to end a sequential read.
// - host builds a bad-block table from factory marks, never erases them; npr_host keeps no table and erases any block it is asked to.
// - on program or erase failure host rewrites elsewhere and retires block; npr_host only reports the failure on o_fail.
// - host corrects single-bit read errors with an ecc, not block swap; npr_host passes read bytes out raw, with no ecc.
// - page read is 00h plus three address cycles.
// - program is 80h, three addresses, data, 10h; no data means no program.
// - erase is 60h, two block-address cycles, then d0h.
`ifndef NPR_PARAMS_SVH
`define NPR_PARAMS_SVH

// command bytes
`define NPR_CMD_AREA_A 8'h00
`define NPR_CMD_AREA_B 8'h01
`define NPR_CMD_AREA_C 8'h50
`define NPR_CMD_LOAD 8'h80
`define NPR_CMD_LOAD_GO 8'h10
`define NPR_CMD_ERASE 8'h60
`define NPR_CMD_ERASE_GO 8'hd0
`define NPR_CMD_STATUS 8'h70
`define NPR_CMD_RESET 8'hff

// layout
`define NPR_BYTE_W 8
`define NPR_PAGE_BYTES 528
`define NPR_ADDR_CYC_PAGE 2'd3
`define NPR_ADDR_CYC_BLOCK 2'd2
`define NPR_ADDR_IDX_COL 2'd0
`define NPR_ADDR_IDX_ROW 2'd1
`define NPR_ST_FAIL_BIT 0
`define NPR_ST_READY_BIT 6

// times as printed, and clock rate
`define NPR_CLK_MHZ 50
`define NPR_T_WP_NS 25
`define NPR_T_WH_NS 15
`define NPR_T_REA_NS 35
`define NPR_T_REH_NS 15
`define NPR_T_WB_NS 100
`define NPR_T_CEH_NS 100
`define NPR_T_WHR_NS 60
`define NPR_T_R_US 7
`define NPR_T_BERS_MS 4
`define NPR_SYNC_LAT 4 // three stages plus the agreement flop

// least times round up to whole cycles
`define NPR_NS_CYC(ns) ((((ns) * `NPR_CLK_MHZ) + 999) / 1000)
`define NPR_WP_CYC `NPR_NS_CYC(`NPR_T_WP_NS)
`define NPR_WH_CYC `NPR_NS_CYC(`NPR_T_WH_NS)
`define NPR_REA_CYC (`NPR_NS_CYC(`NPR_T_REA_NS) + `NPR_SYNC_LAT)
`define NPR_REH_CYC `NPR_NS_CYC(`NPR_T_REH_NS)
`define NPR_WB_CYC (`NPR_NS_CYC(`NPR_T_WB_NS) + `NPR_SYNC_LAT)
`define NPR_CEH_CYC (`NPR_NS_CYC(`NPR_T_CEH_NS) + 1)
`define NPR_WHR_CYC `NPR_NS_CYC(`NPR_T_WHR_NS)
`define NPR_LOAD_CYC (`NPR_T_R_US * `NPR_CLK_MHZ)
`define NPR_BUSY_CYC (`NPR_T_BERS_MS * 1000 * `NPR_CLK_MHZ)

`endif

// ### inc/npr_pkg.sv
// types shared by the page-pointer host controller
// assumes nothing beyond a SystemVerilog compiler
package npr_pkg;

  // operations the user side may request
  typedef enum logic [2:0] {
    NPR_OP_READ,
    NPR_OP_PROG,
    NPR_OP_ERASE,
    NPR_OP_STATUS,
    NPR_OP_RESET
  } npr_op_t;

  // column pointer areas
  typedef enum logic [1:0] {
    NPR_AREA_FIRST,
    NPR_AREA_SECOND,
    NPR_AREA_SPARE
  } npr_area_t;

  // sequencer states
  typedef enum logic [3:0] {
    NPR_S_IDLE,
    NPR_S_CMD,
    NPR_S_ADDR,
    NPR_S_WDATA,
    NPR_S_WB,
    NPR_S_WRDY,
    NPR_S_WHR,
    NPR_S_RDATA,
    NPR_S_CEH
  } npr_state_t;

endpackage

// ### verification/npr_flash_model.sv
// behavioural page flash device with one page of storage
// assumes host pins as driven by npr_host; ready line pulled up outside
module npr_flash_model (
  // pins from the host
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_io,
  // fault control
  input wire logic i_fail,
  // pins to the host
  output logic [7:0] o_io,
  output logic o_ready_busy_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:527];
  logic [7:0] pg [0:527];
  logic [7:0] cmd = 8'hff;
  logic [1:0] ptr = 2'd0;
  int acnt = 0;
  int col = 0;
  int nprog = 0;
  bit loaded = 0;
  bit fail = 0;
  // power-up pointer, erased media with one invalid-block mark
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    mem[517] = 8'h00;
    o_io = 8'h5a;
    o_ready_busy_n = 1'b1;
  end
  // busy for a stretch, then released to the pull-up
  task automatic go_busy(input int ns);
    fork
      begin
        #90 o_ready_busy_n = 1'b0;
        #(ns) o_ready_busy_n = 1'b1;
      end
    join_none
  endtask
  // page load, second half used once
  task automatic load_page();
    foreach (pg[i]) pg[i] = mem[i];
    if (ptr == 2'd1) ptr = 2'd0;
    go_busy(2000);
  endtask
  // program or erase result and pointer after it
  task automatic commit(input int ns);
    fail = i_fail;
    nprog++;
    if (ptr == 2'd1) ptr = 2'd0;
    go_busy(ns);
  endtask
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle) begin
      cmd = i_io;
      acnt = 0;
      case (i_io)
        8'h00: ptr = 2'd0;
        8'h01: ptr = 2'd1;
        8'h50: ptr = 2'd2;
        8'h80: begin
          loaded = 0;
          foreach (pg[i]) pg[i] = 8'hff;
        end
        8'h10: if (loaded && i_wp_n) begin
          foreach (mem[i]) mem[i] &= pg[i];
          commit(3000);
        end
        8'hd0: if (i_wp_n) begin
          foreach (mem[i]) mem[i] = 8'hff;
          commit(4000);
        end
        8'hff: begin
          ptr = 2'd0;
          go_busy(1000);
        end
        default: ;
      endcase
    end else if (!i_ce_n && i_ale) begin
      if (acnt == 0) col = (ptr == 2'd2) ? 512 + i_io[3:0] : {ptr[0], i_io};
      acnt++;
      if (acnt == 3 && cmd inside {8'h00, 8'h01, 8'h50}) load_page();
    end else if (!i_ce_n && cmd == 8'h80) begin
      pg[col] = i_io;
      col++;
      loaded = 1;
    end
  end
  // byte or status out after the strobe falls
  always @(negedge i_re_n) begin
    if (!i_ce_n) #30 o_io = (cmd == 8'h70) ? {i_wp_n, o_ready_busy_n, 5'h0, fail} : pg[col];
  end
  // release data, next page load unless select rose in time
  always @(posedge i_re_n) begin
    #15 o_io = ~o_io;
    if (cmd != 8'h70) begin
      if (col == 527) begin
        #15 if (!i_ce_n) go_busy(2000);
      end else col++;
    end
  end
endmodule

// ### verification/npr_host_assertions.sv
// pin and request checks for the page flash host controller
// assumes it is bound onto npr_host; one clock domain
module npr_host_assertions (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // watched ports
  input wire logic i_ready_busy_n,
  input wire logic o_done,
  input wire logic o_idle,
  input wire logic o_timeout,
  input wire logic o_rd_valid,
  input wire logic o_cle,
  input wire logic o_ale,
  input wire logic o_ce_n,
  input wire logic o_we_n,
  input wire logic o_output_strobe_n,
  input wire logic [7:0] o_io,
  input wire logic o_io_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  // latch events and address bytes since the last command
  logic we_q_r;
  logic [3:0] acnt_r;
  wire we_up = o_we_n && !we_q_r;
  wire cmd_up = we_up && o_cle;
  always_ff @(posedge i_clk) begin
    we_q_r <= o_we_n;
    if (i_rst || cmd_up) begin
      acnt_r <= 4'h0;
    end else if (we_up && o_ale) begin
      acnt_r <= acnt_r + 4'h1;
    end
  end
  ////////////////////////////////////////
  chk_ce_hold: assert property (
    $rose(o_ce_n) |-> o_ce_n [*6]) else $error("select high time too short");
  chk_we_select: assert property (
    !o_we_n |-> !o_ce_n) else $error("write strobe without select");
  chk_strobe_sel: assert property (
    !o_output_strobe_n |-> !o_ce_n && o_we_n && !o_io_oe) else $error("bad read strobe");
  chk_cle_ale: assert property (
    !(o_cle && o_ale)) else $error("command and address latch together");
  chk_erase_addr: assert property (
    cmd_up && o_io == 8'hd0 |-> acnt_r == 4'h2) else $error("erase confirm address count");
  chk_prog_addr: assert property (
    cmd_up && o_io == 8'h10 |-> acnt_r == 4'h3) else $error("program confirm address count");
  chk_busy_cmd: assert property (
    cmd_up && !i_ready_busy_n && !$past(i_ready_busy_n, 4) && !o_timeout
    |-> o_io inside {8'h70, 8'hff}) else $error("command issued while busy");
  chk_done_pulse: assert property (
    o_done |=> !o_done) else $error("done longer than one cycle");
  chk_done_idle: assert property (
    o_done |-> o_idle) else $error("done without idle");
  chk_rd_strobe: assert property (
    o_rd_valid |-> $rose(o_output_strobe_n)) else $error("read byte not at strobe rise");
endmodule

bind npr_host npr_host_assertions chk (.i_clk, .i_rst, .i_ready_busy_n, .o_done, .o_idle,
  .o_timeout, .o_rd_valid, .o_cle, .o_ale, .o_ce_n, .o_we_n, .o_output_strobe_n, .o_io,
  .o_io_oe);

// ### verification/npr_host_tb.sv
// self-checking bench for the page flash host controller
// assumes npr_flash_model on the pins and the bound checker
module npr_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_op_valid = 1'b0;
  npr_pkg::npr_op_t i_op = npr_pkg::NPR_OP_STATUS;
  npr_pkg::npr_area_t i_area = npr_pkg::NPR_AREA_FIRST;
  logic [23:0] i_addr = 24'h0;
  logic [9:0] i_len = 10'h0;
  logic i_wr_valid = 1'b0;
  logic [7:0] i_wr_data = 8'h0;
  logic fail_sel = 1'b0;
  logic o_idle, o_done, o_timeout, o_wr_ready, o_rd_valid, o_fail, o_io_oe;
  logic o_cle, o_ale, o_ce_n, o_we_n, o_output_strobe_n, o_wp_n, rb_n;
  npr_pkg::npr_area_t o_area;
  logic [7:0] o_rd_data, o_status, o_io, dev_io;
  wire [7:0] io_w = o_io_oe ? o_io : dev_io;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] rq[$];
  logic [7:0] wq[$];
  ////////////////////////////////////////
  // controller under test and device on its pins
  npr_host #(.P_BUSY_WAIT(500)) uut (.i_clk, .i_rst, .i_op_valid, .i_op, .i_area, .i_addr,
    .i_len, .o_idle, .o_done, .o_timeout, .o_area, .i_wr_valid, .i_wr_data, .o_wr_ready,
    .o_rd_valid, .o_rd_data, .o_status, .o_fail, .o_cle, .o_ale, .o_ce_n, .o_we_n,
    .o_output_strobe_n, .o_wp_n, .i_io(io_w), .o_io, .o_io_oe, .i_ready_busy_n(rb_n));
  npr_flash_model dev (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
    .i_re_n(o_output_strobe_n), .i_wp_n(o_wp_n), .i_io(io_w), .i_fail(fail_sel),
    .o_io(dev_io), .o_ready_busy_n(rb_n));
  // 50 MHz clock
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request; write bytes from wq, read bytes gathered in rq
  task automatic run_op(input npr_pkg::npr_op_t op, input npr_pkg::npr_area_t ar,
                        input logic [7:0] c, input logic [9:0] n);
    int k;
    int idx;
    bit took;
    idx = 0;
    took = 0;
    k = 0;
    rq.delete();
    @(negedge i_clk);
    i_op = op;
    i_area = ar;
    i_addr = {16'h0001, c};
    i_len = n;
    i_op_valid = 1'b1;
    while (o_idle !== 1'b0 && k < 2000) begin
      @(negedge i_clk);
      k++;
    end
    i_op_valid = 1'b0;
    for (k = 0; k < 5000; k++) begin
      if (took) idx++;
      i_wr_valid = (idx < wq.size());
      i_wr_data = (idx < wq.size()) ? wq[idx] : 8'h00;
      took = i_wr_valid && o_wr_ready;
      @(negedge i_clk);
      if (o_rd_valid === 1'b1) rq.push_back(o_rd_data);
      if (o_done === 1'b1) break;
    end
    i_wr_valid = 1'b0;
    chk({7'h0, o_done}, 8'h1);
    chk({7'h0, o_timeout}, 8'h0);
  endtask
  ////////////////////////////////////////
  task automatic t_status();
    chk({6'h0, o_area}, 8'h0);
    run_op(npr_pkg::NPR_OP_STATUS, npr_pkg::NPR_AREA_FIRST, 8'h0, 10'd0);
    chk(o_status, 8'hc0);
  endtask
  task automatic t_mark();
    run_op(npr_pkg::NPR_OP_READ, npr_pkg::NPR_AREA_SPARE, 8'h05, 10'd11);
    chk(8'(rq.size()), 8'd11);
    foreach (rq[i]) chk(rq[i], (i == 0) ? 8'h00 : 8'hff);
    chk({6'h0, o_area}, {6'h0, npr_pkg::NPR_AREA_SPARE});
    chk({7'h0, rb_n}, 8'h1);
  endtask
  task automatic t_prog_second();
    wq = '{8'ha0, 8'ha1, 8'ha2, 8'ha3};
    run_op(npr_pkg::NPR_OP_PROG, npr_pkg::NPR_AREA_SECOND, 8'h0, 10'd4);
    wq.delete();
    chk({7'h0, o_fail}, 8'h0);
    chk({6'h0, o_area}, {6'h0, npr_pkg::NPR_AREA_FIRST});
  endtask
  task automatic t_read_back();
    run_op(npr_pkg::NPR_OP_READ, npr_pkg::NPR_AREA_FIRST, 8'h0, 10'd2);
    chk(8'(rq.size()), 8'd2);
    foreach (rq[i]) chk(rq[i], 8'hff);
    run_op(npr_pkg::NPR_OP_READ, npr_pkg::NPR_AREA_SECOND, 8'h0, 10'd4);
    chk(8'(rq.size()), 8'd4);
    foreach (rq[i]) chk(rq[i], 8'(8'ha0 + i));
    chk({6'h0, o_area}, {6'h0, npr_pkg::NPR_AREA_FIRST});
  endtask
  task automatic t_fail_spare();
    fail_sel = 1'b1;
    wq = '{8'h3c};
    run_op(npr_pkg::NPR_OP_PROG, npr_pkg::NPR_AREA_SPARE, 8'h02, 10'd1);
    wq.delete();
    fail_sel = 1'b0;
    chk({7'h0, o_fail}, 8'h1);
    chk({6'h0, o_area}, {6'h0, npr_pkg::NPR_AREA_SPARE});
  endtask
  task automatic t_erase();
    run_op(npr_pkg::NPR_OP_ERASE, npr_pkg::NPR_AREA_FIRST, 8'h0, 10'd0);
    chk({7'h0, o_fail}, 8'h0);
    chk({6'h0, o_area}, {6'h0, npr_pkg::NPR_AREA_SPARE});
    run_op(npr_pkg::NPR_OP_READ, npr_pkg::NPR_AREA_SECOND, 8'h0, 10'd1);
    chk(rq[0], 8'hff);
  endtask
  task automatic t_empty_prog();
    int n0;
    n0 = dev.nprog;
    run_op(npr_pkg::NPR_OP_PROG, npr_pkg::NPR_AREA_SPARE, 8'h0, 10'd0);
    chk(8'(dev.nprog - n0), 8'h0);
    run_op(npr_pkg::NPR_OP_RESET, npr_pkg::NPR_AREA_SPARE, 8'h0, 10'd0);
    chk({6'h0, o_area}, {6'h0, npr_pkg::NPR_AREA_FIRST});
  endtask
  ////////////////////////////////////////
  // main sequence after six reset cycles
  initial begin
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    t_status();
    t_mark();
    t_prog_second();
    t_read_back();
    t_fail_spare();
    t_erase();
    t_empty_prog();
    close_out();
  end
  // watchdog well past the expected run length
  initial begin
    #400000;
    bad_count++;
    close_out();
  end
endmodule
